// >>> logic/dsci_regs.svh
`ifndef DSCI_REGS_SVH
`define DSCI_REGS_SVH

// Register byte offsets on the APB bus.
`define DSCI_OFF_CTRL 8'h00
`define DSCI_OFF_CYC 8'h04
`define DSCI_OFF_DATA 8'h08
`define DSCI_OFF_STAT 8'h0c

// Control register width, reset value and bit positions.
`define DSCI_CTRL_W 11
`define DSCI_CTRL_RST 11'h060
`define DSCI_CTRL_MUX 0
`define DSCI_CTRL_IO_A 1
`define DSCI_CTRL_HI0 3
`define DSCI_CTRL_HI1 4
`define DSCI_CTRL_RST_A 5
`define DSCI_CTRL_VPP_A 7
`define DSCI_CTRL_SEL_IN 9
`define DSCI_CTRL_INIT 10

// Cycle register width; a write to it while idle launches one card cycle.
`define DSCI_CYC_W 21

// Status register field positions.
`define DSCI_STAT_BUSY 0
`define DSCI_STAT_A_LO 1
`define DSCI_STAT_B_LO 9
`define DSCI_STAT_WIDE 17

// Cycle timing, in nanoseconds and derived clock counts.
`define DSCI_CLK_MHZ 50
`define DSCI_SETUP_NS 30
`define DSCI_STRB_NS 100
`define DSCI_HOLD_NS 20
`define DSCI_SETUP_CYC ((`DSCI_SETUP_NS * `DSCI_CLK_MHZ + 999) / 1000)
`define DSCI_STRB_CYC ((`DSCI_STRB_NS * `DSCI_CLK_MHZ + 999) / 1000)
`define DSCI_HOLD_CYC ((`DSCI_HOLD_NS * `DSCI_CLK_MHZ + 999) / 1000)

`endif

// >>> logic/dsci_pkg.sv
package dsci_pkg;

    // Phases of one card cycle.
    typedef enum logic [1:0] {
        DSCI_IDLE,
        DSCI_SETUP,
        DSCI_STRB,
        DSCI_HOLD
    } dsci_phase_t;

    // Card address spaces.
    typedef enum logic [1:0] {
        DSCI_COMMON,
        DSCI_ATTR,
        DSCI_IO
    } dsci_space_t;

    // One card cycle request as written to the cycle register.
    typedef struct packed {
        logic wide;
        logic write;
        dsci_space_t space;
        logic sock;
        logic [15:0] addr;
    } dsci_cyc_t;

    // Pins arriving from one socket.
    typedef struct packed {
        logic present_n;
        logic ready;
        logic wp;
        logic bvd1;
        logic bvd2;
    } dsci_sock_in_t;

    // Pins driven toward one socket.
    typedef struct packed {
        logic high_en_n;
        logic low_en_n;
        logic attr_sel_n;
        logic reset;
        logic vpp;
    } dsci_sock_out_t;

    // Interpreted state of one socket.
    typedef struct packed {
        logic present;
        logic ready;
        logic irq;
        logic wprot;
        logic batt1;
        logic batt2;
        logic stschg;
        logic audio;
    } dsci_sock_stat_t;

    // Whole state of the controller.
    typedef struct packed {
        dsci_phase_t phase;
        logic [10:0] ctrl;
        dsci_cyc_t cyc;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [3:0] cnt;
    } dsci_state_t;

endpackage

// >>> logic/dsci_sock.sv
`timescale 1ns/10ps
`default_nettype none

module dsci_sock (
    // Cycle decode
    input wire logic sel,
    input wire dsci_pkg::dsci_cyc_t cyc,
    input wire logic wide_ok,
    // Socket configuration
    input wire logic io_mode,
    input wire logic rst,
    input wire logic vpp,
    // Socket pins
    input wire dsci_pkg::dsci_sock_in_t pin_in,
    output var dsci_pkg::dsci_sock_out_t pin_out,
    // Interpreted socket state
    output var dsci_pkg::dsci_sock_stat_t stat
);

    logic dual;

    // Byte enables, space select, reset and programming supply.
    always_comb begin
        dual = cyc.wide & wide_ok;
        pin_out.high_en_n = ~(sel & (dual | cyc.addr[0]));
        pin_out.low_en_n = ~(sel & (dual | ~cyc.addr[0]));
        pin_out.attr_sel_n = ~(sel & (cyc.space != dsci_pkg::DSCI_COMMON));
        pin_out.reset = rst;
        pin_out.vpp = vpp;
    end

    // Input pins read according to the card type.
    always_comb begin
        stat.present = ~pin_in.present_n;
        stat.ready = ~io_mode & pin_in.ready;
        stat.irq = io_mode & pin_in.ready;
        stat.wprot = ~io_mode & pin_in.wp;
        stat.batt1 = ~io_mode & pin_in.bvd1;
        stat.stschg = io_mode & ~pin_in.bvd1;
        stat.batt2 = ~io_mode & pin_in.bvd2;
        stat.audio = io_mode & pin_in.bvd2;
    end

endmodule

`default_nettype wire

// >>> logic/dsci_top.sv
// Notes on behaviour
// - Buffer direction is high for writes to a card, low for reads.
// - High-byte enable of a socket goes low for odd bytes of that card.
// - Low-byte enable of a socket goes low for even bytes of that card.
// - Attribute select stays high for common memory, low for attribute memory.
// - Attribute select is also low during every card I/O access.
// - Printer select-in pin may become the card memory read strobe.
// - Printer initialise pin may become the card memory write strobe.
// - A low cycle-extend input stretches the cycle until it is released.
// - Each socket has a high card reset output, returning it to memory mode.
// - Ready input means ready for memory cards, interrupt for socket A I/O.
// - Write-protect input shows the card switch for memory cards.
// - Both write-protect inputs are ORed into a low 16-bit I/O indication.
// - Card address bits 24 and 25 come from configuration, shared by sockets.
// - A low card-detect input means the card sits properly in its socket.
// - First battery input is battery state, or low status change for I/O.
// - Second battery input is battery state, or card audio for I/O.
// - Each socket has a high programming voltage enable output.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`include "dsci_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module dsci_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shared card address and data
    output logic [15:0] card_addr,
    output logic card_addr_bit_hi0,
    output logic card_addr_bit_hi1,
    input wire logic [15:0] card_data_in,
    output logic [15:0] card_data_out,
    output logic card_data_oe,
    output logic card_buffer_direction,
    // Shared card control
    output logic card_io_read_n,
    output logic card_io_write_n,
    input wire logic card_cycle_extend_n,
    output logic wide_io_port_flag_n,
    // Parallel port pins shared with card strobes
    output logic printer_select_in_n,
    output logic printer_init_n,
    // Socket A pins
    output logic socket_a_high_byte_enable_n,
    output logic socket_a_low_byte_enable_n,
    output logic socket_a_attr_sel_n,
    output logic socket_a_reset,
    output logic socket_a_vpp,
    input wire logic socket_a_present_n,
    input wire logic socket_a_ready,
    input wire logic socket_a_wp,
    input wire logic socket_a_battery_status_one,
    input wire logic socket_a_battery_status_two,
    // Socket B pins
    output logic socket_b_high_byte_enable_n,
    output logic socket_b_low_byte_enable_n,
    output logic socket_b_attr_sel_n,
    output logic socket_b_reset,
    output logic socket_b_vpp,
    input wire logic socket_b_present_n,
    input wire logic socket_b_ready,
    input wire logic socket_b_wp,
    input wire logic socket_b_battery_status_one,
    input wire logic socket_b_battery_status_two,
    // Card events toward the system
    output logic socket_a_card_interrupt,
    output logic card_status_change,
    output logic [1:0] card_audio_in
);

    localparam int NSOCK = 2;

    dsci_pkg::dsci_state_t s;
    dsci_pkg::dsci_state_t s_next;
    dsci_pkg::dsci_sock_in_t sin [NSOCK];
    dsci_pkg::dsci_sock_out_t sout [NSOCK];
    dsci_pkg::dsci_sock_stat_t sstat [NSOCK];
    logic busy;
    logic in_strb;
    logic mem_cyc;
    logic io_cyc;
    logic wide_ok;
    logic acc;
    logic wr_acc;
    logic hit_ctrl;
    logic hit_cyc;
    logic hit_data;
    logic hit_stat;
    logic card_read_strobe_n;
    logic card_write_strobe_n;

    // Cycle qualifiers decoded from the state.
    assign busy = (s.phase != dsci_pkg::DSCI_IDLE);
    assign in_strb = (s.phase == dsci_pkg::DSCI_STRB);
    assign io_cyc = (s.cyc.space == dsci_pkg::DSCI_IO);
    assign mem_cyc = ~io_cyc;

    // APB address decode and access qualifiers.
    always_comb begin
        hit_ctrl = 1'b0;
        hit_cyc = 1'b0;
        hit_data = 1'b0;
        hit_stat = 1'b0;
        if (paddr == `DSCI_OFF_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == `DSCI_OFF_CYC) begin
            hit_cyc = 1'b1;
        end else if (paddr == `DSCI_OFF_DATA) begin
            hit_data = 1'b1;
        end else if (paddr == `DSCI_OFF_STAT) begin
            hit_stat = 1'b1;
        end
    end

    assign acc = psel & penable;
    assign wr_acc = acc & pwrite;
    assign pready = 1'b1;

    // Unmapped addresses and a new cycle while one runs both answer with an error.
    assign pslverr = acc & (~(hit_ctrl | hit_cyc | hit_data | hit_stat)
                            | (hit_cyc & pwrite & busy));

    // Socket pins gathered into per-socket carriers.
    assign sin[0] = {socket_a_present_n, socket_a_ready, socket_a_wp,
                     socket_a_battery_status_one, socket_a_battery_status_two};
    assign sin[1] = {socket_b_present_n, socket_b_ready, socket_b_wp,
                     socket_b_battery_status_one, socket_b_battery_status_two};

    assign wide_io_port_flag_n = socket_a_wp | socket_b_wp;
    assign wide_ok = mem_cyc | ~wide_io_port_flag_n;

    // One decoder per socket; only the socket named by the cycle is selected.
    for (genvar g = 0; g < NSOCK; g++) begin : g_sock
        dsci_sock dsci_sock_inst (
            .sel(busy & (s.cyc.sock == 1'(g))),
            .cyc(s.cyc),
            .wide_ok(wide_ok),
            .io_mode(s.ctrl[`DSCI_CTRL_IO_A + g]),
            .rst(s.ctrl[`DSCI_CTRL_RST_A + g]),
            .vpp(s.ctrl[`DSCI_CTRL_VPP_A + g]),
            .pin_in(sin[g]),
            .pin_out(sout[g]),
            .stat(sstat[g])
        );
        assign card_audio_in[g] = sstat[g].audio;
    end

    // Socket outputs spread onto their pins.
    assign socket_a_high_byte_enable_n = sout[0].high_en_n;
    assign socket_a_low_byte_enable_n = sout[0].low_en_n;
    assign socket_a_attr_sel_n = sout[0].attr_sel_n;
    assign socket_a_reset = sout[0].reset;
    assign socket_a_vpp = sout[0].vpp;
    assign socket_b_high_byte_enable_n = sout[1].high_en_n;
    assign socket_b_low_byte_enable_n = sout[1].low_en_n;
    assign socket_b_attr_sel_n = sout[1].attr_sel_n;
    assign socket_b_reset = sout[1].reset;
    assign socket_b_vpp = sout[1].vpp;

    assign socket_a_card_interrupt = sstat[0].irq;
    assign card_status_change = sstat[0].stschg | sstat[1].stschg;

    // memory strobes only inside a strobe phase
    assign card_read_strobe_n = ~(in_strb & mem_cyc & ~s.cyc.write);
    assign card_write_strobe_n = ~(in_strb & mem_cyc & s.cyc.write);
    assign card_io_read_n = ~(in_strb & io_cyc & ~s.cyc.write);
    assign card_io_write_n = ~(in_strb & io_cyc & s.cyc.write);

    // pin sharing with the parallel port
    assign printer_select_in_n = s.ctrl[`DSCI_CTRL_MUX] ? card_read_strobe_n :
                                 ~s.ctrl[`DSCI_CTRL_SEL_IN];
    assign printer_init_n = s.ctrl[`DSCI_CTRL_MUX] ? card_write_strobe_n :
                            ~s.ctrl[`DSCI_CTRL_INIT];

    assign card_buffer_direction = busy & s.cyc.write;
    assign card_data_oe = busy & s.cyc.write;
    assign card_data_out = s.wdata;
    assign card_addr = s.cyc.addr;

    assign card_addr_bit_hi0 = s.ctrl[`DSCI_CTRL_HI0];
    assign card_addr_bit_hi1 = s.ctrl[`DSCI_CTRL_HI1];

    // Register read mux; unmapped addresses read as zero.
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_ctrl) begin
            prdata[`DSCI_CTRL_W-1:0] = s.ctrl;
        end else if (hit_cyc) begin
            prdata[`DSCI_CYC_W-1:0] = s.cyc;
        end else if (hit_data) begin
            prdata[15:0] = s.rdata;
        end else if (hit_stat) begin
            prdata[`DSCI_STAT_BUSY] = busy;
            prdata[`DSCI_STAT_A_LO +: 8] = sstat[0];
            prdata[`DSCI_STAT_B_LO +: 8] = sstat[1];
            prdata[`DSCI_STAT_WIDE] = wide_io_port_flag_n;
        end
    end

    // Next state: register writes and the card cycle sequencer.
    always_comb begin
        s_next = s;
        if (wr_acc & hit_ctrl) begin
            s_next.ctrl = pwdata[`DSCI_CTRL_W-1:0];
        end
        if (wr_acc & hit_data) begin
            s_next.wdata = pwdata[15:0];
        end
        case (s.phase)
            dsci_pkg::DSCI_IDLE: begin
                if (wr_acc & hit_cyc) begin
                    s_next.cyc = pwdata[`DSCI_CYC_W-1:0];
                    s_next.phase = dsci_pkg::DSCI_SETUP;
                    s_next.cnt = 4'(`DSCI_SETUP_CYC - 1);
                end
            end
            dsci_pkg::DSCI_SETUP: begin
                if (s.cnt == 4'h0) begin
                    s_next.phase = dsci_pkg::DSCI_STRB;
                    s_next.cnt = 4'(`DSCI_STRB_CYC - 1);
                end else begin
                    s_next.cnt = s.cnt - 4'h1;
                end
            end
            dsci_pkg::DSCI_STRB: begin
                if (s.cnt != 4'h0) begin
                    s_next.cnt = s.cnt - 4'h1;
                // wait states while extend is low
                end else if (card_cycle_extend_n) begin
                    if (~s.cyc.write) begin
                        s_next.rdata = card_data_in;
                    end
                    s_next.phase = dsci_pkg::DSCI_HOLD;
                    s_next.cnt = 4'(`DSCI_HOLD_CYC - 1);
                end
            end
            dsci_pkg::DSCI_HOLD: begin
                if (s.cnt == 4'h0) begin
                    s_next.phase = dsci_pkg::DSCI_IDLE;
                end else begin
                    s_next.cnt = s.cnt - 4'h1;
                end
            end
            default: begin
                s_next.phase = dsci_pkg::DSCI_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.phase <= dsci_pkg::DSCI_IDLE;
            s.ctrl <= `DSCI_CTRL_RST;
            s.cyc <= '0;
            s.wdata <= 16'h0000;
            s.rdata <= 16'h0000;
            s.cnt <= 4'h0;
        end else begin
            s <= s_next;
        end
    end

    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_dir_follow: assert property (
        busy |-> card_buffer_direction == s.cyc.write && card_data_oe == s.cyc.write)
        else $error("buffer direction differs from cycle direction");

    a_high_byte: assert property (
        !socket_a_high_byte_enable_n |-> busy && !s.cyc.sock && (s.cyc.addr[0] || s.cyc.wide))
        else $error("socket a high byte enable without odd access");

    a_low_byte: assert property (
        busy && s.cyc.sock && !s.cyc.addr[0] |-> !socket_b_low_byte_enable_n)
        else $error("socket b low byte enable missing for even access");

    a_attr_common: assert property (
        busy && !s.cyc.sock && s.cyc.space == dsci_pkg::DSCI_COMMON |-> socket_a_attr_sel_n)
        else $error("attribute select low during common access");

    a_attr_io: assert property (
        busy && s.cyc.sock && io_cyc |-> !socket_b_attr_sel_n)
        else $error("attribute select high during io access");

    a_read_strobe: assert property (
        $rose(in_strb) && s.ctrl[`DSCI_CTRL_MUX] && mem_cyc && !s.cyc.write
        |-> !printer_select_in_n [*5])
        else $error("read strobe shorter than five cycles");

    a_write_strobe: assert property (
        s.phase == dsci_pkg::DSCI_SETUP && s.cnt == 4'h0 && s.ctrl[`DSCI_CTRL_MUX]
        && mem_cyc && s.cyc.write |=> !printer_init_n [*5])
        else $error("write strobe shorter than five cycles");

    a_wait_extend: assert property (
        in_strb && s.cnt == 4'h0 && !card_cycle_extend_n |=> in_strb)
        else $error("cycle ended while extend was low");

    a_cycle_end: assert property (
        in_strb && s.cnt == 4'h0 && card_cycle_extend_n
        |=> s.phase == dsci_pkg::DSCI_HOLD ##1 !busy)
        else $error("cycle did not close after extend released");

    a_card_reset: assert property (
        wr_acc && hit_ctrl && pwdata[`DSCI_CTRL_RST_A] |=> socket_a_reset)
        else $error("socket a reset not driven after control write");

    a_idle_quiet: assert property (
        !busy |-> socket_a_high_byte_enable_n && socket_b_low_byte_enable_n
        && card_read_strobe_n && card_write_strobe_n)
        else $error("enable or strobe active with no cycle");

    a_other_quiet: assert property (
        busy && s.cyc.sock |-> socket_a_high_byte_enable_n && socket_a_low_byte_enable_n)
        else $error("socket a enable active during socket b cycle");

    a_io_no_mem: assert property (
        busy && io_cyc && s.ctrl[`DSCI_CTRL_MUX] |-> printer_select_in_n && printer_init_n)
        else $error("memory strobe active during io cycle");

    a_read_capture: assert property (
        in_strb && s.cnt == 4'h0 && card_cycle_extend_n && !s.cyc.write
        |=> s.rdata == $past(card_data_in))
        else $error("read data not captured at end of strobe");

endmodule

`default_nettype wire

// >>> verif/dsci_card.sv
`timescale 1ns/10ps
`default_nettype none

// Behavioural cards in both sockets: answer reads, take writes, stretch strobes.
module dsci_card (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Card bus from the controller
    input wire logic [15:0] card_addr,
    input wire logic [15:0] card_data_out,
    input wire logic [3:0] enables_n,
    input wire logic [3:0] strobes_n,
    // Bench commands
    input wire logic [3:0] stall_len,
    input wire logic [3:0] contacts_n,
    // Card answers
    output logic [15:0] card_data_in,
    output logic card_cycle_extend_n,
    output logic socket_a_present_n,
    output logic socket_b_present_n,
    output logic [15:0] last_write
);
    logic [1:0] sel, wait_n;
    logic act, rd;
    logic [4:0] cnt;
    logic [15:0] held;

    // A socket is addressed while either of its byte enables is low.
    assign sel = {~&enables_n[3:2], ~&enables_n[1:0]};
    assign act = ~&strobes_n & |sel;
    assign rd = (~strobes_n[0] | ~strobes_n[2]) & |sel;
    assign socket_a_present_n = contacts_n[0] & contacts_n[1];
    assign socket_b_present_n = contacts_n[2] & contacts_n[3];
    // Each card holds its wait low for stall_len cycles from the fifth strobe cycle.
    assign wait_n[0] = !(sel[0] && act && cnt >= 5'd4 && cnt < 5'd4 + {1'b0, stall_len});
    assign wait_n[1] = !(sel[1] && act && cnt >= 5'd4 && cnt < 5'd4 + {1'b0, stall_len});
    assign card_cycle_extend_n = wait_n[0] & wait_n[1];
    // A released bus shows the inverse of its last value, never a stale copy.
    assign card_data_in = rd ? {~card_addr[7:0], card_addr[7:0]} : ~held;

    // Count strobe cycles and keep what a write delivered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 5'h00;
            held <= 16'h0000;
            last_write <= 16'h0000;
        end else begin
            cnt <= act ? cnt + 5'h01 : 5'h00;
            if (rd) begin
                held <= {~card_addr[7:0], card_addr[7:0]};
            end
            if (act && !rd) begin
                last_write <= card_data_out;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/dsci_top_test.sv
`include "dsci_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module dsci_top_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [15:0] card_addr, card_data_in, card_data_out, last_write, wdat;
    logic card_addr_bit_hi0, card_addr_bit_hi1, card_data_oe, card_buffer_direction;
    logic card_io_read_n, card_io_write_n, card_cycle_extend_n, wide_io_port_flag_n;
    logic printer_select_in_n, printer_init_n, socket_a_card_interrupt, card_status_change;
    logic [1:0] card_audio_in;
    logic socket_a_high_byte_enable_n, socket_a_low_byte_enable_n, socket_a_attr_sel_n;
    logic socket_a_reset, socket_a_vpp, socket_a_present_n, socket_a_ready, socket_a_wp;
    logic socket_a_battery_status_one, socket_a_battery_status_two;
    logic socket_b_high_byte_enable_n, socket_b_low_byte_enable_n, socket_b_attr_sel_n;
    logic socket_b_reset, socket_b_vpp, socket_b_present_n, socket_b_ready, socket_b_wp;
    logic socket_b_battery_status_one, socket_b_battery_status_two;
    logic [3:0] stall_len, contacts_n;
    int failures, total_checks, cycles;

    dsci_top dsci_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .card_addr, .card_addr_bit_hi0, .card_addr_bit_hi1,
        .card_data_in, .card_data_out, .card_data_oe, .card_buffer_direction,
        .card_io_read_n, .card_io_write_n, .card_cycle_extend_n, .wide_io_port_flag_n,
        .printer_select_in_n, .printer_init_n, .socket_a_high_byte_enable_n,
        .socket_a_low_byte_enable_n, .socket_a_attr_sel_n, .socket_a_reset, .socket_a_vpp,
        .socket_a_present_n, .socket_a_ready, .socket_a_wp, .socket_a_battery_status_one,
        .socket_a_battery_status_two, .socket_b_high_byte_enable_n,
        .socket_b_low_byte_enable_n, .socket_b_attr_sel_n, .socket_b_reset, .socket_b_vpp,
        .socket_b_present_n, .socket_b_ready, .socket_b_wp, .socket_b_battery_status_one,
        .socket_b_battery_status_two, .socket_a_card_interrupt, .card_status_change,
        .card_audio_in);

    dsci_card dsci_card_inst (.pclk, .presetn, .card_addr, .card_data_out,
        .enables_n({socket_b_high_byte_enable_n, socket_b_low_byte_enable_n,
            socket_a_high_byte_enable_n, socket_a_low_byte_enable_n}),
        .strobes_n({card_io_write_n, card_io_read_n, printer_init_n, printer_select_in_n}),
        .stall_len, .contacts_n, .card_data_in, .card_cycle_extend_n, .socket_a_present_n,
        .socket_b_present_n, .last_write);

    // Free-running 50 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Cut a hung run short.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    task give_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is seen at a rising edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Launch one card cycle and judge the pins seen while its strobe is low.
    task automatic card_cycle(input logic [20:0] c, input logic [3:0] st);
        int s;
        logic both, strb;
        logic [4:0] seen, exp;
        logic [1:0] other;
        stall_len <= st;
        apb(1'b1, `DSCI_OFF_CYC, {11'h000, c});
        s = 0;
        both = c[20] & ((c[18:17] == 2'd2) ? ~(socket_a_wp | socket_b_wp) : 1'b1);
        exp = {~(both | c[0]), ~(both | ~c[0]), c[18:17] == 2'd0, c[19], c[19]};
        repeat (40) begin
            @(negedge pclk);
            strb = (c[18:17] == 2'd2) ? (c[19] ? card_io_write_n : card_io_read_n)
                : (c[19] ? printer_init_n : printer_select_in_n);
            if (strb === 1'b0) begin
                s++;
                seen = c[16] ? {socket_b_high_byte_enable_n, socket_b_low_byte_enable_n,
                    socket_b_attr_sel_n, card_buffer_direction, card_data_oe}
                    : {socket_a_high_byte_enable_n, socket_a_low_byte_enable_n,
                    socket_a_attr_sel_n, card_buffer_direction, card_data_oe};
                other = c[16] ? {socket_a_high_byte_enable_n, socket_a_low_byte_enable_n}
                    : {socket_b_high_byte_enable_n, socket_b_low_byte_enable_n};
            end else if (s > 0) begin
                break;
            end
        end
        chk(s, 5 + st);
        chk(seen, exp);
        chk(other, 2'b11);
        apb(1'b0, `DSCI_OFF_STAT, 32'h0);
        chk(rq[0], 1'b0);
        if (c[19]) begin
            chk(last_write, wdat);
        end else begin
            apb(1'b0, `DSCI_OFF_DATA, 32'h0);
            chk(rq, {16'h0000, ~c[7:0], c[7:0]});
        end
    endtask

    task t_reset;
        apb(1'b0, `DSCI_OFF_CTRL, 32'h0);
        chk(rq, 32'h060);
        chk({socket_a_reset, socket_b_reset, socket_a_vpp, socket_b_vpp}, 4'hc);
        chk({socket_a_high_byte_enable_n, socket_a_low_byte_enable_n,
            socket_b_high_byte_enable_n, socket_b_low_byte_enable_n}, 4'hf);
        $display("test reset done");
    endtask

    task t_config;
        apb(1'b1, `DSCI_OFF_CTRL, 32'h089);
        @(negedge pclk);
        chk({card_addr_bit_hi1, card_addr_bit_hi0}, 2'b01);
        chk({socket_a_reset, socket_b_reset, socket_a_vpp, socket_b_vpp}, 4'h2);
        apb(1'b1, `DSCI_OFF_CTRL, 32'h750);
        @(negedge pclk);
        chk({card_addr_bit_hi1, card_addr_bit_hi0}, 2'b10);
        chk({socket_a_reset, socket_b_reset, socket_a_vpp, socket_b_vpp}, 4'h5);
        chk({printer_select_in_n, printer_init_n}, 2'b00);
        apb(1'b0, `DSCI_OFF_CTRL, 32'h0);
        chk(rq, 32'h750);
        apb(1'b0, 8'h10, 32'h0);
        chk({re, rq[3:0]}, 5'h10);
        $display("test config done");
    endtask

    // Every socket, memory space, direction and byte lane, with growing wait stretches.
    task t_memory;
        logic [20:0] c;
        apb(1'b1, `DSCI_OFF_CTRL, 32'h001);
        for (int i = 0; i < 8; i++) begin
            wdat = 16'ha5c0 + i[15:0];
            apb(1'b1, `DSCI_OFF_DATA, {16'h0000, wdat});
            c = {i == 7, i[2], 1'b0, i[1], i[0], 12'h3c4, 1'b0, i[2:1], i[0] ^ i[1]};
            card_cycle(c, i[3:0]);
        end
        $display("test memory done");
    endtask

    task t_io;
        apb(1'b1, `DSCI_OFF_CTRL, 32'h003);
        card_cycle(21'h150101, 4'h0);
        socket_a_wp <= 1'b1;
        wdat = 16'h5aa5;
        apb(1'b1, `DSCI_OFF_DATA, {16'h0000, wdat});
        chk(wide_io_port_flag_n, 1'b1);
        card_cycle(21'h0c0203, 4'h2);
        socket_a_ready <= 1'b1;
        socket_a_battery_status_one <= 1'b0;
        socket_a_battery_status_two <= 1'b1;
        @(negedge pclk);
        chk(socket_a_card_interrupt, 1'b1);
        chk(card_status_change, 1'b1);
        chk(card_audio_in[0], 1'b1);
        $display("test io done");
    endtask

    task t_status;
        apb(1'b1, `DSCI_OFF_CTRL, 32'h001);
        contacts_n <= 4'hc;
        socket_b_battery_status_one <= 1'b1;
        apb(1'b0, `DSCI_OFF_STAT, 32'h0);
        chk(rq & 32'h3b9b8, 32'h211a8);
        chk(socket_a_card_interrupt, 1'b0);
        $display("test status done");
    endtask

    // Main sequence.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {socket_a_ready, socket_a_wp, socket_b_ready, socket_b_wp} = 4'h0;
        {socket_a_battery_status_one, socket_a_battery_status_two} = 2'b11;
        {socket_b_battery_status_one, socket_b_battery_status_two} = 2'b00;
        stall_len = 4'h0;
        contacts_n = 4'h0;
        wdat = 16'h0000;
        {failures, total_checks} = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_config();
        t_memory();
        t_io();
        t_status();
        give_verdict();
    end
endmodule
`default_nettype wire
